// ===== logic/brb_bridge.sv
// Two-wire slave bridge carrying the single-wire read-byte command flow
// Operation
// - Pointer change accepted while read-byte runs
// - Read-data pointer returns sampled byte
// - Pointer change framed write, restart, read
// - Busy 0 when idle, command accepted
// - Busy reads 1 while command executes
// - Read-byte command during busy is not acknowledged
`timescale 1ns/1ps
module brb_bridge
  import brb_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_drv_out,
  output logic      sda_oe_out,
  input  wire logic line_in,
  output logic      line_drv_out,
  output logic      line_oe_out,
  output logic      line_busy_flag_out
);

  // Three-stage synchronisers: index 0 scl, 1 sda, 2 line
  logic [2:0]   sync1_reg;
  logic [2:0]   sync2_reg;
  logic [2:0]   sync3_reg;
  logic [2:0]   filt_reg;
  logic [2:0]   filt_prev_reg;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_det;
  logic         stop_det;

  brb_i2c_type  i_state_reg;
  brb_kind_type kind_reg;
  brb_ptr_type  ptr_reg;
  logic [7:0]   shift_reg;
  logic [2:0]   bit_cnt_reg;
  logic         byte_done_reg;
  logic         ack_reg;
  logic         rw_reg;
  logic         host_ack_reg;
  logic         start_rb_reg;

  brb_line_type w_state_reg;
  logic [9:0]   slot_cnt_reg;
  logic [2:0]   rx_cnt_reg;
  logic [7:0]   rx_shift_reg;
  logic [7:0]   read_data_reg;
  logic         busy_reg;
  logic         pend_reg;
  logic [7:0]   tx_load;

  function automatic logic [7:0] status_byte(input logic busy);
    logic [7:0] s;
    s = 8'h00;
    s[STAT_BUSY_BIT] = busy;
    return s;
  endfunction

  // Byte that the next read transfer shifts out, picked by the read pointer
  assign tx_load = (ptr_reg == BRB_PTR_DATA) ? read_data_reg : status_byte(busy_reg);

  // A change counts only once stages two and three agree
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_reg     <= 3'h7;
      sync2_reg     <= 3'h7;
      sync3_reg     <= 3'h7;
      filt_reg      <= 3'h7;
      filt_prev_reg <= 3'h7;
    end else begin
      sync1_reg     <= {line_in, sda_in, scl_in};
      sync2_reg     <= sync1_reg;
      sync3_reg     <= sync2_reg;
      filt_reg      <= (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (filt_reg & (sync2_reg ^ sync3_reg));
      filt_prev_reg <= filt_reg;
    end
  end

  assign scl_rise  = filt_reg[0] & ~filt_prev_reg[0];
  assign scl_fall  = ~filt_reg[0] & filt_prev_reg[0];
  assign start_det = filt_reg[0] & filt_prev_reg[0] & ~filt_reg[1] & filt_prev_reg[1];
  assign stop_det  = filt_reg[0] & filt_prev_reg[0] & filt_reg[1] & ~filt_prev_reg[1];

  // Two-wire slave sequencing
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      i_state_reg   <= BRB_I_IDLE;
      kind_reg      <= BRB_KIND_ADDR;
      ptr_reg       <= BRB_PTR_STATUS;
      shift_reg     <= 8'h00;
      bit_cnt_reg   <= 3'h0;
      byte_done_reg <= 1'b0;
      ack_reg       <= 1'b0;
      rw_reg        <= 1'b0;
      host_ack_reg  <= 1'b0;
      start_rb_reg  <= 1'b0;
      sda_oe_out    <= 1'b0;
    end else begin
      start_rb_reg <= 1'b0;
      if (start_det) begin
        i_state_reg   <= BRB_I_RX;
        kind_reg      <= BRB_KIND_ADDR;
        bit_cnt_reg   <= 3'h0;
        byte_done_reg <= 1'b0;
        sda_oe_out    <= 1'b0;
      end else if (stop_det) begin
        i_state_reg <= BRB_I_IDLE;
        sda_oe_out  <= 1'b0;
      end else begin
        unique case (i_state_reg)
          BRB_I_IDLE: begin
            sda_oe_out <= 1'b0;
          end
          BRB_I_RX: begin
            if (scl_rise) begin
              shift_reg     <= {shift_reg[6:0], filt_reg[1]};
              bit_cnt_reg   <= bit_cnt_reg + 3'h1;
              byte_done_reg <= (bit_cnt_reg == BITS_PER_BYTE);
            end else if (scl_fall && byte_done_reg) begin
              byte_done_reg <= 1'b0;
              i_state_reg   <= BRB_I_ACK;
              ack_reg       <= 1'b0;
              sda_oe_out    <= 1'b0;
              unique case (kind_reg)
                BRB_KIND_ADDR: begin
                  if (shift_reg[7:1] == SLAVE_ADDR) begin
                    ack_reg    <= 1'b1;
                    sda_oe_out <= 1'b1;
                    rw_reg     <= shift_reg[0];
                  end
                end
                BRB_KIND_CMD: begin
                  if (shift_reg == LINE_READ_BYTE_CMD && !busy_reg) begin
                    ack_reg      <= 1'b1;
                    sda_oe_out   <= 1'b1;
                    start_rb_reg <= 1'b1;
                    ptr_reg      <= BRB_PTR_STATUS;
                  end else if (shift_reg == SET_READ_POINTER_CMD) begin
                    ack_reg    <= 1'b1;
                    sda_oe_out <= 1'b1;
                  end
                  // A read-byte code while busy falls through unacknowledged
                end
                BRB_KIND_PARAM: begin
                  if (shift_reg == PTR_READ_DATA) begin
                    ack_reg    <= 1'b1;
                    sda_oe_out <= 1'b1;
                    ptr_reg    <= BRB_PTR_DATA;
                  end else if (shift_reg == PTR_STATUS) begin
                    ack_reg    <= 1'b1;
                    sda_oe_out <= 1'b1;
                    ptr_reg    <= BRB_PTR_STATUS;
                  end
                end
                default: begin
                end
              endcase
            end
          end
          BRB_I_ACK: begin
            if (scl_fall) begin
              bit_cnt_reg <= 3'h0;
              if (!ack_reg) begin
                i_state_reg <= BRB_I_IDLE;
                sda_oe_out  <= 1'b0;
              end else if (kind_reg == BRB_KIND_ADDR && rw_reg) begin
                // Status is fetched fresh for every byte so polling sees busy fall
                i_state_reg <= BRB_I_TX;
                shift_reg   <= tx_load;
                sda_oe_out  <= ~tx_load[7];
              end else begin
                i_state_reg <= BRB_I_RX;
                sda_oe_out  <= 1'b0;
                unique case (kind_reg)
                  BRB_KIND_ADDR:  kind_reg <= BRB_KIND_CMD;
                  BRB_KIND_CMD:   kind_reg <= (shift_reg == SET_READ_POINTER_CMD) ? BRB_KIND_PARAM : BRB_KIND_NONE;
                  default:        kind_reg <= BRB_KIND_NONE;
                endcase
              end
            end
          end
          BRB_I_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == BITS_PER_BYTE) begin
                i_state_reg <= BRB_I_TXACK;
                sda_oe_out  <= 1'b0;
              end else begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                shift_reg   <= {shift_reg[6:0], 1'b0};
                sda_oe_out  <= ~shift_reg[6];
              end
            end
          end
          BRB_I_TXACK: begin
            if (scl_rise) begin
              host_ack_reg <= ~filt_reg[1];
            end else if (scl_fall) begin
              bit_cnt_reg <= 3'h0;
              if (host_ack_reg) begin
                i_state_reg <= BRB_I_TX;
                shift_reg   <= tx_load;
                sda_oe_out  <= ~tx_load[7];
              end else begin
                i_state_reg <= BRB_I_IDLE;
                sda_oe_out  <= 1'b0;
              end
            end
          end
        endcase
      end
    end
  end

  // Single-wire read-byte sequencer; runs apart from the pointer so a pointer change cannot disturb it
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      w_state_reg   <= BRB_W_IDLE;
      slot_cnt_reg  <= 10'h000;
      rx_cnt_reg    <= 3'h0;
      rx_shift_reg  <= DATA_RESET;
      read_data_reg <= DATA_RESET;
      busy_reg      <= 1'b0;
      pend_reg      <= 1'b0;
      line_oe_out   <= 1'b0;
    end else begin
      unique case (w_state_reg)
        BRB_W_IDLE: begin
          line_oe_out <= 1'b0;
          if (start_rb_reg || pend_reg) begin
            w_state_reg  <= BRB_W_SLOT;
            busy_reg     <= 1'b1;
            pend_reg     <= 1'b0;
            slot_cnt_reg <= 10'h000;
            rx_cnt_reg   <= 3'h0;
            line_oe_out  <= 1'b1;
          end
        end
        BRB_W_SLOT: begin
          slot_cnt_reg <= slot_cnt_reg + 10'h001;
          line_oe_out  <= (slot_cnt_reg + 10'h001 < LOW_CYC);
          if (slot_cnt_reg == SAMPLE_CYC) begin
            // Bits arrive least significant first
            rx_shift_reg <= {filt_reg[2], rx_shift_reg[7:1]};
            if (rx_cnt_reg == BITS_PER_BYTE) begin
              read_data_reg <= {filt_reg[2], rx_shift_reg[7:1]};
              busy_reg      <= 1'b0;
            end
          end
          // Busy falls before the last recovery ends, so an accepted command waits for it
          if (start_rb_reg) begin
            busy_reg <= 1'b1;
            pend_reg <= 1'b1;
          end
          if (slot_cnt_reg == SLOT_CYC - 10'h001) begin
            slot_cnt_reg <= 10'h000;
            rx_cnt_reg   <= rx_cnt_reg + 3'h1;
            if (rx_cnt_reg == BITS_PER_BYTE && !pend_reg) begin
              w_state_reg <= BRB_W_IDLE;
              line_oe_out <= 1'b0;
            end else begin
              line_oe_out <= 1'b1;
              if (rx_cnt_reg == BITS_PER_BYTE) pend_reg <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // Both pins are open drain: only a low is ever driven
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sda_drv_out        <= 1'b0;
      line_drv_out       <= 1'b0;
      line_busy_flag_out <= 1'b0;
    end else begin
      sda_drv_out        <= 1'b0;
      line_drv_out       <= 1'b0;
      line_busy_flag_out <= busy_reg;
    end
  end

endmodule // brb_bridge

// ===== logic/brb_pkg.sv
// Constants for the two-wire to single-wire read-byte bridge
package brb_pkg;

  // Clock and single-wire slot timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned T_LOW_NS      = 6000;   // Least low time that opens a read slot
  localparam int unsigned T_SAMPLE_NS   = 15000;  // Longest time from slot start to sampling
  localparam int unsigned T_SLOT_NS     = 70000;  // Least slot length, recovery included
  localparam int unsigned LOW_CYC_I     = (T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SAMPLE_CYC_I  = T_SAMPLE_NS / CLK_PERIOD_NS;
  localparam int unsigned SLOT_CYC_I    = (T_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0]  LOW_CYC       = 10'(LOW_CYC_I);
  localparam logic [9:0]  SAMPLE_CYC    = 10'(SAMPLE_CYC_I);
  localparam logic [9:0]  SLOT_CYC      = 10'(SLOT_CYC_I);

  // Two-wire slave address and command codes
  localparam logic [6:0]  SLAVE_ADDR           = 7'h18;
  localparam logic [7:0]  LINE_READ_BYTE_CMD   = 8'h96;
  localparam logic [7:0]  SET_READ_POINTER_CMD = 8'hE1;
  localparam logic [7:0]  PTR_READ_DATA        = 8'hE1;
  localparam logic [7:0]  PTR_STATUS           = 8'hF0;

  // Status byte layout and reset values
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  localparam logic [2:0]  BITS_PER_BYTE = 3'h7;

  typedef enum logic {
    BRB_PTR_STATUS,
    BRB_PTR_DATA
  } brb_ptr_type;

  typedef enum logic [1:0] {
    BRB_KIND_ADDR,
    BRB_KIND_CMD,
    BRB_KIND_PARAM,
    BRB_KIND_NONE
  } brb_kind_type;

  typedef enum logic [2:0] {
    BRB_I_IDLE,
    BRB_I_RX,
    BRB_I_ACK,
    BRB_I_TX,
    BRB_I_TXACK
  } brb_i2c_type;

  typedef enum logic {
    BRB_W_IDLE,
    BRB_W_SLOT
  } brb_line_type;

endpackage

// ===== sim/brb_chk.sv
// Port checker for the read-byte bridge, bound to the design
`timescale 1ns/1ps
module brb_chk
  import brb_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic scl_in,
  input wire logic sda_drv_out,
  input wire logic sda_oe_out,
  input wire logic line_drv_out,
  input wire logic line_oe_out,
  input wire logic line_busy_flag_out
);
  // Sample of the last slot falls on count SAMPLE_CYC, its own cycle included
  localparam int BUSY_CYC = 7 * SLOT_CYC_I + SAMPLE_CYC_I + 1;
  logic [12:0] busy_cnt_reg;
  logic [12:0] gap_cnt_reg;
  logic        late_reg;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_cnt_reg <= 13'h0;
      gap_cnt_reg  <= 13'h0;
      late_reg     <= 1'b0;
    end else begin
      busy_cnt_reg <= line_busy_flag_out ? busy_cnt_reg + 13'h1 : 13'h0;
      gap_cnt_reg  <= $rose(line_oe_out) ? 13'h1 : gap_cnt_reg + 13'h1;
      // A command taken during the last recovery waits, so its busy span is longer
      if ($rose(line_busy_flag_out)) late_reg <= !$past(line_oe_out);
    end
  end
  property p_busy_start;
    $rose(line_oe_out) && !line_busy_flag_out |-> ##1 line_busy_flag_out [*8];
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy flag late at line start");
  property p_busy_len;
    $fell(line_busy_flag_out) && !late_reg |-> busy_cnt_reg == BUSY_CYC;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy flag length wrong");
  property p_busy_slot;
    $rose(line_oe_out) |-> ##1 line_busy_flag_out;
  endproperty
  a_busy_slot: assert property (p_busy_slot) else $error("slot driven while not busy");
  property p_slot_gap;
    $rose(line_oe_out) && line_busy_flag_out |-> gap_cnt_reg == SLOT_CYC_I;
  endproperty
  a_slot_gap: assert property (p_slot_gap) else $error("running byte disturbed");
  property p_idle_quiet;
    line_oe_out && !line_busy_flag_out |-> $rose(line_oe_out);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("line driven while idle");
  property p_sda_frame;
    $changed(sda_oe_out) |-> !scl_in;
  endproperty
  a_sda_frame: assert property (p_sda_frame) else $error("data pin moved with clock high");
  property p_open_drain;
    !sda_drv_out && !line_drv_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high");
  c_start: cover property ($rose(line_busy_flag_out));
  c_done: cover property ($fell(line_busy_flag_out));
  c_ack: cover property ($rose(sda_oe_out));
endmodule // brb_chk

bind brb_bridge brb_chk i_chk (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .scl_in(scl_in),
  .sda_drv_out(sda_drv_out), .sda_oe_out(sda_oe_out), .line_drv_out(line_drv_out),
  .line_oe_out(line_oe_out), .line_busy_flag_out(line_busy_flag_out));

// ===== sim/brb_host.sv
// Two-wire host master model driving the bridge
`timescale 1ns/1ps
module brb_host (
  input  wire logic ref_clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic q;
    repeat (10) @(posedge ref_clk_in);
  endtask
  // Serves as start and repeated start
  task automatic start;
    sda_oe_out <= 1'b0;
    q();
    scl_out <= 1'b1;
    q();
    sda_oe_out <= 1'b1;
    q();
    scl_out <= 1'b0;
    q();
  endtask
  task automatic stop;
    sda_oe_out <= 1'b1;
    q();
    scl_out <= 1'b1;
    q();
    sda_oe_out <= 1'b0;
    q();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_oe_out <= !b;
    q();
    scl_out <= 1'b1;
    q();
    r = sda_in;
    q();
    scl_out <= 1'b0;
    q();
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Polling acks while busy is seen and nacks the idle status
  task automatic rd_byte(input logic poll, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(!(poll && b[0]), r);
  endtask
endmodule // brb_host

// ===== sim/brb_bridge_tb_top.sv
// Testbench for the read-byte bridge
`timescale 1ns/1ps
module brb_bridge_tb_top;
  import brb_pkg::*;
  logic       ref_clk_in = 1'b0;
  logic       rstn_in;
  logic       scl;
  logic       sda_drv;
  logic       sda_oe;
  logic       host_oe;
  logic       line_drv;
  logic       line_oe;
  logic       busy;
  logic       pull_reg = 1'b0;
  logic       prev_reg = 1'b1;
  logic [2:0] bit_reg  = 3'h0;
  logic [9:0] hold_reg = 10'h0;
  logic [7:0] tx_byte;
  int         seed;
  int         mismatches = 0;
  int         cmp_count = 0;
  wire        sda  = !(host_oe | sda_oe);
  wire        line = !(line_oe | pull_reg);
  always #50 ref_clk_in = !ref_clk_in;
  brb_bridge i_dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda),
    .sda_drv_out(sda_drv), .sda_oe_out(sda_oe), .line_in(line), .line_drv_out(line_drv),
    .line_oe_out(line_oe), .line_busy_flag_out(busy));
  brb_host i_host (.ref_clk_in(ref_clk_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(host_oe));
  // Far-end slave: a zero bit holds the line low past the sample point
  always @(posedge ref_clk_in) begin
    prev_reg <= line;
    if (prev_reg && !line) begin
      pull_reg <= !tx_byte[bit_reg];
      bit_reg  <= bit_reg + 3'h1;
      hold_reg <= 10'h12C;
    end else if (hold_reg != 10'h0) hold_reg <= hold_reg - 10'h1;
    else pull_reg <= 1'b0;
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cmd(input logic [7:0] c, output logic ack);
    logic a;
    i_host.start();
    i_host.wr_byte({SLAVE_ADDR, 1'b0}, a);
    i_host.wr_byte(c, ack);
  endtask
  task automatic set_ptr(input logic [7:0] code);
    logic a;
    logic b;
    cmd(SET_READ_POINTER_CMD, a);
    i_host.wr_byte(code, b);
    chk("pointer ack", 8'h01, {7'h0, a && b});
  endtask
  // Only the busy flag may be set in the status byte
  function automatic logic [7:0] exp_status(input logic b);
    logic [7:0] s;
    s = 8'h00;
    s[STAT_BUSY_BIT] = b;
    return s;
  endfunction
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    // About twice the four read-byte operations with their host traffic
    repeat (8 * (8 * SLOT_CYC_I + 2500)) @(posedge ref_clk_in);
    mismatches++;
    final_report();
  end
  initial begin
    logic       ack;
    logic [7:0] st;
    int         n;
    seed = 44655;
    rstn_in = 1'b0;
    tx_byte = 8'h00;
    repeat (6) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    for (int op = 0; op < 4; op++) begin
      tx_byte <= (op == 0) ? 8'h00 : (op == 1) ? 8'hFF : 8'($random(seed));
      cmd(LINE_READ_BYTE_CMD, ack);
      chk("command ack", 8'h01, {7'h0, ack});
      if (op[0]) begin
        i_host.start();
        i_host.wr_byte({SLAVE_ADDR, 1'b1}, ack);
        n = 0;
        do begin
          i_host.rd_byte(1'b1, st);
          n++;
          if (n == 1) chk("status busy", exp_status(1'b1), st);
        end while (st[0] && n < 40);
        chk("status idle", exp_status(1'b0), st);
        set_ptr(PTR_READ_DATA);
      end else begin
        i_host.stop();
        chk("busy flag", 8'h01, {7'h0, busy});
        cmd(LINE_READ_BYTE_CMD, ack);
        chk("busy command ack", 8'h00, {7'h0, ack});
        i_host.stop();
        set_ptr(PTR_READ_DATA);
        i_host.stop();
        n = 0;
        while (busy !== 1'b0 && n < 6000) begin
          @(posedge ref_clk_in);
          n++;
        end
        chk("busy flag", 8'h00, {7'h0, busy});
      end
      i_host.start();
      i_host.wr_byte({SLAVE_ADDR, 1'b1}, ack);
      i_host.rd_byte(1'b0, st);
      i_host.stop();
      chk("read data", tx_byte, st);
      if (op == 3) begin
        set_ptr(PTR_STATUS);
        i_host.start();
        i_host.wr_byte({SLAVE_ADDR, 1'b1}, ack);
        i_host.rd_byte(1'b0, st);
        i_host.stop();
        chk("status pointer", exp_status(1'b0), st);
      end
    end
    final_report();
  end
endmodule // brb_bridge_tb_top
